// File: common/sram_port_pkg.sv
// Package holding the constants, register map and types of the burst memory port.
package sram_port_pkg;

	// ----------------------------------------------------------------
	// Organisation
	// ----------------------------------------------------------------
	localparam int DEF_ADDR_W = 20;
	localparam int DEF_DATA_W = 36;
	localparam int DEF_LANES  = 4;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  OFS_STATUS = 4'h0;
	localparam logic [3:0]  OFS_CTRL   = 4'h4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int          CTRL_SLEEP = 0;
	localparam int          ST_SLEEP   = 0;
	localparam int          ST_OP_LO   = 1;
	localparam int          ST_LSB_LO  = 3;
	localparam int          ST_BYPASS  = 5;
	localparam int          ST_ORDER   = 6;
	localparam int          ST_CNT_LO  = 7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_READ  = 2'b01,
		OP_WRITE = 2'b10,
		OP_DESEL = 2'b11
	} mem_op_t;

	// Burst position: linear adds the count, interleaved XORs it.
	function automatic logic [1:0] burst_lsb(input logic [1:0] base, input logic [1:0] cnt,
		input logic interleave);
		burst_lsb = interleave ? (base ^ cnt) : (base + cnt);
	endfunction

endpackage

// File: hdl/sync_burst_sram_port.sv
// Synchronous burst static memory port with single-cycle deselect and status registers.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - Synchronous pins sampled on rising clock only.
// - Output enable and sleep act asynchronously.
// - Either address strobe loads burst counter.
// - Two-bit counter advances only on advance low.
// - Order strap: low linear, high interleaved.
// - New address accepted every cycle.
// - Bypass strap low: read data same cycle.
// - Bypass strap high: one extra output register.
// - Bypass strap high: deselect pipelined one stage less than read.
// - Drivers turn off right after deselect capture.
// - Byte write stores only selected lanes.
// - Global write stores every lane.
// - Writes are timed internally after capture.
// - Sleep on sleep request or stopped clock.
// - Memory contents kept through sleep.
// - Four addresses per burst, wrap on fifth.
// - Data pins undriven during any write.
// - Reads drive all lanes regardless of selects.
module sync_burst_sram_port
	import sram_port_pkg::*;
#(
	parameter int ADDR_W = DEF_ADDR_W,
	parameter int DATA_W = DEF_DATA_W,
	parameter int LANES  = DEF_LANES
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] data_in,
	output logic      [DATA_W-1:0] data_out,
	output logic      [DATA_W-1:0] data_oe_n,
	input  wire logic              chip_select_n,
	input  wire logic              cpu_addr_strobe_n,
	input  wire logic              ctrl_addr_strobe_n,
	input  wire logic              burst_advance_n,
	input  wire logic              byte_write_en_n,
	input  wire logic              all_lanes_write_n,
	input  wire logic [LANES-1:0]  byte_lane_sel_n,
	input  wire logic              output_enable_n,
	input  wire logic              sleep_request,
	input  wire logic              burst_order_sel,
	input  wire logic              output_bypass_sel,
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest
);

	localparam int LANE_W = DATA_W / LANES;

	// ----------------------------------------------------------------
	// Pin synchronisers for sleep and straps
	// ----------------------------------------------------------------
	logic [1:0] sleep_sync;
	logic [1:0] order_sync;
	logic [1:0] bypass_sync;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sleep_sync  <= 2'b00;
			order_sync  <= 2'b00;
			bypass_sync <= 2'b11;
		end else begin
			sleep_sync  <= {sleep_sync[0], sleep_request};
			order_sync  <= {order_sync[0], burst_order_sel};
			bypass_sync <= {bypass_sync[0], output_bypass_sel};
		end
	end

	logic force_sleep;
	logic sleep_active;
	logic order_q;
	logic bypass_q;

	assign order_q      = order_sync[1];
	assign bypass_q     = bypass_sync[1];
	// A stopped clock freezes every flop, which is the clock-stop sleep.
	assign sleep_active = sleep_sync[1] | force_sleep;

	// ----------------------------------------------------------------
	// Command decode from pins sampled at the edge
	// ----------------------------------------------------------------
	logic strobe_now;
	logic start_now;
	logic desel_now;
	logic cont_now;
	logic adv_now;
	logic write_now;
	logic burst_live;

	assign strobe_now = ~cpu_addr_strobe_n | ~ctrl_addr_strobe_n;
	assign start_now  = strobe_now & ~chip_select_n & ~sleep_active;
	assign desel_now  = strobe_now & chip_select_n & ~sleep_active;
	assign cont_now   = ~strobe_now & burst_live & ~sleep_active;
	assign adv_now    = cont_now & ~burst_advance_n;
	assign write_now  = ~all_lanes_write_n | (~byte_write_en_n & ~(&byte_lane_sel_n));

	mem_op_t cur_op;
	mem_op_t next_op;

	always_comb begin
		next_op = OP_IDLE;
		if (start_now || cont_now) begin
			next_op = write_now ? OP_WRITE : OP_READ;
		end else if (desel_now) begin
			next_op = OP_DESEL;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cur_op     <= OP_IDLE;
			burst_live <= 1'b0;
		end else begin
			cur_op <= next_op;
			if (start_now) begin
				burst_live <= 1'b1;
			end else if (desel_now || sleep_active) begin
				burst_live <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Burst address counter
	// ----------------------------------------------------------------
	logic [ADDR_W-3:0] addr_hi;
	logic [1:0]        burst_base;
	logic [1:0]        burst_cnt;
	logic [1:0]        access_lsb;
	logic [ADDR_W-1:0] access_addr;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			addr_hi    <= '0;
			burst_base <= 2'b00;
			burst_cnt  <= 2'b00;
		end else if (start_now) begin
			addr_hi    <= addr[ADDR_W-1:2];
			burst_base <= addr[1:0];
			burst_cnt  <= 2'b00;
		end else if (adv_now) begin
			burst_cnt <= burst_cnt + 2'b01;
		end
	end

	assign access_lsb  = burst_lsb(burst_base, burst_cnt, order_q);
	assign access_addr = {addr_hi, access_lsb};

	// ----------------------------------------------------------------
	// Write capture and storage array
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] wdata_q;
	logic [LANES-1:0]  wmask_q;
	logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wdata_q <= '0;
			wmask_q <= '0;
		end else if (next_op == OP_WRITE) begin
			wdata_q <= data_in;
			if (!all_lanes_write_n) begin
				wmask_q <= '1;
			end else begin
				wmask_q <= ~byte_lane_sel_n;
			end
		end
	end

	// The array has no reset so contents survive reset and sleep alike.
	always_ff @(posedge core_clk) begin
		if (cur_op == OP_WRITE) begin
			for (int i = 0; i < LANES; i++) begin
				if (wmask_q[i]) begin
					mem[access_addr][i*LANE_W +: LANE_W] <= wdata_q[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path and output drivers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] pipe_q;
	logic              pipe_read_q;
	logic              drive;

	assign rd_word = mem[access_addr];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pipe_q      <= '0;
			pipe_read_q <= 1'b0;
		end else begin
			pipe_read_q <= (cur_op == OP_READ);
			if (cur_op == OP_READ) begin
				pipe_q <= rd_word;
			end
		end
	end

	// A captured deselect or write cuts the drive at once in both modes.
	always_comb begin
		drive = 1'b0;
		unique case (cur_op)
			OP_READ:  drive = bypass_q ? pipe_read_q : 1'b1;
			OP_IDLE:  drive = bypass_q & pipe_read_q;
			OP_WRITE: drive = 1'b0;
			OP_DESEL: drive = 1'b0;
		endcase
	end

	assign data_out  = bypass_q ? pipe_q : rd_word;
	assign data_oe_n = {DATA_W{~(drive & ~output_enable_n & ~sleep_request & ~sleep_active)}};

	// ----------------------------------------------------------------
	// Avalon-MM register slave
	// ----------------------------------------------------------------
	logic        ack_q;
	logic [31:0] status_word;

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

	always_comb begin
		status_word                          = '0;
		status_word[ST_SLEEP]                = sleep_active;
		status_word[ST_OP_LO +: 2]           = cur_op;
		status_word[ST_LSB_LO +: 2]          = access_lsb;
		status_word[ST_BYPASS]               = bypass_q;
		status_word[ST_ORDER]                = order_q;
		status_word[ST_CNT_LO +: 2]          = burst_cnt;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
			if (avs_read && !ack_q) begin
				unique case (avs_address)
					OFS_STATUS: avs_readdata <= status_word;
					OFS_CTRL:   avs_readdata <= {31'h0000_0000, force_sleep};
					default:    avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			force_sleep <= CTRL_RESET[CTRL_SLEEP];
		end else if (avs_write && ack_q && avs_address == OFS_CTRL && avs_byteenable[0]) begin
			force_sleep <= avs_writedata[CTRL_SLEEP];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_read_start;
		start_now && !write_now;
	endsequence

	sequence s_read_issue;
		cur_op == OP_READ;
	endsequence

	property p_start_load;
		start_now |=> (burst_cnt == 2'b00 && burst_base == $past(addr[1:0]));
	endproperty
	a_start_load: assert property (p_start_load) else $error("Strobe did not load counter.");

	property p_advance;
		(adv_now && !start_now) |=> burst_cnt == $past(burst_cnt) + 2'b01;
	endproperty
	a_advance: assert property (p_advance) else $error("Counter did not advance.");

	property p_hold;
		(!start_now && !adv_now) |=> $stable(burst_cnt);
	endproperty
	a_hold: assert property (p_hold) else $error("Counter moved without advance.");

	property p_wrap;
		(burst_cnt == 2'b11 && adv_now && $stable(order_q)) |=> access_lsb == burst_base;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Burst did not wrap to start.");

	property p_global_write;
		(start_now && !all_lanes_write_n == 1'b1) |=> (cur_op == OP_WRITE && &wmask_q);
	endproperty
	a_global_write: assert property (p_global_write) else $error("Global write missed a lane.");

	property p_partial;
		(start_now && all_lanes_write_n && !byte_write_en_n && !(&byte_lane_sel_n))
			|=> wmask_q == ~$past(byte_lane_sel_n);
	endproperty
	a_partial: assert property (p_partial) else $error("Byte write mask wrong.");

	property p_no_drive_write;
		cur_op == OP_WRITE |-> &data_oe_n;
	endproperty
	a_no_drive_write: assert property (p_no_drive_write) else $error("Driving during write.");

	property p_deselect_fast;
		desel_now |=> &data_oe_n;
	endproperty
	a_deselect_fast: assert property (p_deselect_fast) else $error("Deselect left drivers on.");

	property p_pipe_latency;
		s_read_start ##0 bypass_q |=> s_read_issue ##1 pipe_read_q;
	endproperty
	a_pipe_latency: assert property (p_pipe_latency) else $error("Registered read timing wrong.");

	property p_flow_drive;
		(s_read_issue and (!bypass_q && !output_enable_n && !sleep_request && !sleep_active))
			|-> !data_oe_n[0] && data_out == rd_word;
	endproperty
	a_flow_drive: assert property (p_flow_drive) else $error("Flow read not driven.");

	property p_oe_gate;
		output_enable_n |-> &data_oe_n;
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("Drivers on with enable high.");

	property p_sleep_idle;
		sleep_active |=> (cur_op == OP_IDLE && !burst_live);
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("Command accepted in sleep.");

endmodule

// File: dv/mem_ctrl_model.sv
// Controller model that drives the memory pins of the burst port.
`timescale 1ns/1ps
module mem_ctrl_model (
	input  wire logic   core_clk,
	output logic [5:0]  addr,
	output logic [35:0] data_in,
	output logic        chip_select_n,
	output logic        cpu_addr_strobe_n,
	output logic        ctrl_addr_strobe_n,
	output logic        burst_advance_n,
	output logic        all_lanes_write_n,
	output logic        byte_write_en_n,
	output logic [3:0]  byte_lane_sel_n,
	output logic        output_enable_n,
	output logic        sleep_request
);
	initial begin
		{addr, data_in, sleep_request} = '0;
		{chip_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = '1;
		{all_lanes_write_n, byte_write_en_n, byte_lane_sel_n, output_enable_n} = '1;
	end

	// A command is set right after an edge and held for capture at the next one.
	// A data bus that carries no write data shows the inverse of its last value.
	task automatic op(input int k, input logic cs, input logic [5:0] a, input logic [5:0] wc,
		input logic [35:0] d, input logic oe, input logic zz);
		@(posedge core_clk);
		cpu_addr_strobe_n <= (k != 2);
		ctrl_addr_strobe_n <= (k != 3);
		burst_advance_n <= (k != 1);
		chip_select_n <= cs;
		addr <= (k >= 2) ? a : ~addr;
		{all_lanes_write_n, byte_write_en_n, byte_lane_sel_n} <= wc;
		data_in <= (wc[5] && (wc[4] || &wc[3:0])) ? ~data_in : d;
		output_enable_n <= oe;
		sleep_request <= zz;
	endtask
endmodule

// File: dv/sync_burst_sram_port_test.sv
// Self-checking bench for the burst memory port against a reference model.
`timescale 1ns/1ps
module sync_burst_sram_port_test;
	import sram_port_pkg::*;
	logic        core_clk, reset, burst_order_sel, output_bypass_sel;
	logic [5:0]  addr, base, n;
	logic [35:0] data_in, data_out, data_oe_n, r;
	logic        chip_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
	logic        byte_write_en_n, all_lanes_write_n, output_enable_n, sleep_request, live;
	logic [3:0]  byte_lane_sel_n, avs_address, avs_byteenable;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [35:0] ref_mem [64];
	logic [36:0] exp_a [int];
	logic [1:0]  cnt;
	int          errors, n_checks, cyc, seed, i, j;

	sync_burst_sram_port #(.ADDR_W(6), .DATA_W(36), .LANES(4)) sync_burst_sram_port_inst (.*);
	mem_ctrl_model mem_ctrl_model_inst (.*);

	initial begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// Checking and stimulus tasks
	// ----------------------------------------------------------------
	function automatic logic [35:0] rnd();
		logic [63:0] t;
		t = {$random(seed), $random(seed)};
		return t[35:0];
	endfunction

	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One memory cycle: the model drives the pins, the outputs for later cycles are predicted, then this cycle is checked.
	task automatic step(input int k, input logic cs, input logic [5:0] a, input logic [5:0] wc,
		input logic oe = 0, input logic zz = 0);
		logic [35:0] d;
		logic [5:0]  p;
		d = rnd();
		mem_ctrl_model_inst.op(k, cs, a, wc, d, oe, zz);
		if (zz) begin
			live = 0;
		end else if (k >= 2 && cs) begin
			live = 0;
			exp_a[cyc+1] = '0;
		end else begin
			if (k >= 2) begin
				base = a;
				cnt = 0;
				live = 1;
			end else if (k == 1 && live) begin
				cnt = cnt + 1;
			end
			p = {base[5:2], burst_order_sel ? base[1:0] ^ cnt : base[1:0] + cnt};
			// A cycle with no strobe and no advance repeats the access at the same address.
			if (live && (!wc[5] || (!wc[4] && wc[3:0] != 4'hf))) begin
				for (j = 0; j < 4; j++)
					if (!wc[5] || !wc[j]) ref_mem[p][j*9+:9] = d[j*9+:9];
				exp_a[cyc+1] = '0;
			end else if (live) begin
				exp_a[cyc+1+output_bypass_sel] = {1'b1, ref_mem[p]};
			end
		end
		@(negedge core_clk);
		if (oe || zz) exp_a[cyc] = '0;
		if (exp_a.exists(cyc)) begin
			chk("data_oe_n", {36{!exp_a[cyc][36]}}, data_oe_n);
			if (exp_a[cyc][36]) chk("data_out", exp_a[cyc][35:0], data_out);
			exp_a.delete(cyc);
		end
		cyc++;
	endtask

	task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hf;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h4214_d728;
		{errors, n_checks, cyc, live, base, cnt} = '0;
		{reset, burst_order_sel, output_bypass_sel} = 3'b100;
		{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
		repeat (6) @(posedge core_clk);
		reset <= 0;
		for (i = 0; i < 4; i++) begin
			@(posedge core_clk);
			burst_order_sel <= i[0];
			output_bypass_sel <= i[1];
			repeat (3) @(posedge core_clk);
			for (n = 0; n < 4; n++) step(2 + n[0], 0, 6'h10 + n, 6'h1f);
			r = rnd();
			step(2, 0, 6'h11, {2'b10, r[3:0]});
			step(3, 0, 6'h12, 6'h30);
			step(2, 0, 6'h13, 6'h2f);
			step(3, 0, {4'h4, r[5:4]}, 6'h3f);
			step(1, 0, 0, 6'h3f);
			step(0, 0, 0, 6'h3f);
			for (n = 0; n < 3; n++) step(1, 0, 0, 6'h3f);
			step(2, 1, 0, 6'h3f);
			step(3, 0, 6'h12, 6'h3f);
			for (n = 0; n < 2; n++) step(0, 0, 0, 6'h3f, 1);
			for (n = 0; n < 3; n++) step(0, 0, 0, 6'h3f);
			step(2, 1, 0, 6'h3f);
			$display("mode test %0d done", i);
		end
		avs(1, OFS_CTRL, 32'h0000_0001, rd);
		avs(0, OFS_CTRL, 0, rd);
		chk("ctrl", 36'h0_0000_0001, {4'h0, rd});
		avs(0, OFS_STATUS, 0, rd);
		chk("status", 36'h0_0000_0007, {33'h0, rd[6:5], rd[0]});
		avs(0, 4'hc, 0, rd);
		chk("unmapped", 36'h0, {4'h0, rd});
		avs(1, OFS_CTRL, 0, rd);
		$display("register test done");
		for (n = 0; n < 3; n++) step(0, 0, 0, 6'h3f, 0, 1);
		step(3, 0, 6'h10, 6'h1f, 0, 1);
		for (n = 0; n < 3; n++) step(0, 0, 0, 6'h3f);
		step(2, 0, 6'h10, 6'h3f);
		for (n = 0; n < 3; n++) step(0, 0, 0, 6'h3f);
		$display("sleep test done");
		end_sim();
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		errors++;
		end_sim();
	end
endmodule
